// [logic/spm_pkg.sv]
`default_nettype none
package spm_pkg;

   // operation codes, decimal 420 421 424 425
   localparam logic [9:0] FN_MUL_S  = 10'h1A4;
   localparam logic [9:0] FN_MUL_SL = 10'h1A5;
   localparam logic [9:0] FN_MUL_B  = 10'h1A8;
   localparam logic [9:0] FN_MUL_BL = 10'h1A9;

   localparam int         W_WORD       = 16;
   localparam int         W_ADDR       = 16;
   localparam logic [2:0] SLOT_COUNT   = 3'h4;
   localparam logic [6:0] DAB_STEPS    = 7'h40;
   localparam logic [2:0] RES_WORDS_S  = 3'h2;
   localparam logic [2:0] RES_WORDS_D  = 3'h4;
   localparam logic       FLAG_RST     = 1'h0;
   localparam logic [9:0] FUNC_RST     = 10'h000;

   typedef enum logic [2:0] {
      S_IDLE, S_FETCH, S_MUL, S_PROD, S_DAB, S_WRITE, S_FIN
   } spm_state_e;

   typedef struct packed {
      logic [9:0]        func;
      logic [W_ADDR-1:0] mcand_addr;
      logic [W_ADDR-1:0] mplier_addr;
      logic [W_ADDR-1:0] res_addr;
      logic              mcand_const;
      logic              mplier_const;
      logic [31:0]       mcand_imm;
      logic [31:0]       mplier_imm;
   } spm_req_s;

   typedef struct packed {
      spm_state_e             st;
      spm_req_s               req;
      logic [3:0][W_WORD-1:0] opd;
      logic [2:0]             idx;
      logic                   rd_pend;
      logic [1:0]             rd_slot;
      logic                   rd;
      logic [W_ADDR-1:0]      raddr;
      logic                   we;
      logic [W_ADDR-1:0]      waddr;
      logic [W_WORD-1:0]      wdata;
      logic                   bad;
      logic [63:0]            res;
      logic [63:0]            bin;
      logic [6:0]             cnt;
      logic                   busy;
      logic                   done;
      logic                   zero;
      logic                   neg;
      logic                   err;
   } spm_core_s;

   typedef struct packed {
      logic [63:0] p;
   } spm_mul_s;

   function automatic logic is_bcd_word(input logic [15:0] w);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (w[4*i +: 4] > 4'h9) ok = 1'b0;
      end
      return ok;
   endfunction : is_bcd_word

   function automatic logic is_double(input logic [9:0] f);
      return (f == FN_MUL_SL) || (f == FN_MUL_BL);
   endfunction : is_double

   function automatic logic is_bcd_op(input logic [9:0] f);
      return (f == FN_MUL_B) || (f == FN_MUL_BL);
   endfunction : is_bcd_op

   function automatic logic is_known(input logic [9:0] f);
      return (f == FN_MUL_S) || (f == FN_MUL_SL) || is_bcd_op(f);
   endfunction : is_known

   function automatic logic [31:0] bcd_to_bin(input logic [31:0] d);
      logic [31:0] v;
      v = 32'h0000_0000;
      for (int i = 7; i >= 0; i--) begin
         v = v * 32'h0000_000A + {28'h000_0000, d[4*i +: 4]};
      end
      return v;
   endfunction : bcd_to_bin

   function automatic logic [63:0] dab_adjust(input logic [63:0] b);
      logic [63:0] r;
      r = b;
      for (int i = 0; i < 16; i++) begin
         if (r[4*i +: 4] > 4'h4) r[4*i +: 4] = r[4*i +: 4] + 4'h3;
      end
      return r;
   endfunction : dab_adjust

endpackage : spm_pkg
`default_nettype wire

// [logic/spm_mul.sv]
`timescale 1ns/1ps
`default_nettype none
// registered 33x33 signed product, low 64 bits kept
module spm_mul (
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic signed [32:0] a,
   input  wire logic signed [32:0] b,
   output logic [63:0]             p
);
   spm_pkg::spm_mul_s q;
   spm_pkg::spm_mul_s n;
   logic signed [65:0] full;

   always_comb begin
      full = a * b;
      n.p  = full[63:0];
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q.p <= 64'h0000_0000_0000_0000;
      end else begin
         q <= n;
      end
   end

   assign p = q.p;
endmodule : spm_mul
`default_nettype wire

// [logic/spm_unit.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - codes 420/421 signed; operands stored or constant
// - codes 424/425 are BCD four/eight digit
// - 16x16 signed gives 32-bit, two words
// - 32x32 signed gives 64-bit, four words
// - four-digit BCD product, two result words
// - eight-digit BCD product, four result words
// - zero flag set when whole product zero
// - negative flag is signed product top bit; BCD leaves it unchanged
// - single BCD: error on bad operand digit
// - double BCD: error on any bad word
// - double signed operands stored or constant too
module spm_unit (
   input  wire logic              CLK,
   input  wire logic              NRST,
   input  wire logic              START,
   input  wire spm_pkg::spm_req_s REQ,
   input  wire logic [15:0]       STOR_RDATA,
   output logic                   STOR_RD,
   output logic [15:0]            STOR_RADDR,
   output logic                   STOR_WE,
   output logic [15:0]            STOR_WADDR,
   output logic [15:0]            STOR_WDATA,
   output logic                   BUSY,
   output logic                   DONE,
   output logic                   ZERO_FLAG,
   output logic                   NEG_FLAG,
   output logic                   ERROR_FLAG
);
   spm_pkg::spm_core_s q;
   spm_pkg::spm_core_s n;
   logic signed [32:0] mul_a;
   logic signed [32:0] mul_b;
   logic [63:0]        prod;

   ////////////////////////////////////////////////////////////////////////////
   // operand shaping; mul_a/mul_b read the captured words, product one edge later
   always_comb begin
      if (spm_pkg::is_bcd_op(q.req.func)) begin
         mul_a = {1'b0, spm_pkg::bcd_to_bin({q.opd[1], q.opd[0]})};
         mul_b = {1'b0, spm_pkg::bcd_to_bin({q.opd[3], q.opd[2]})};
      end else if (spm_pkg::is_double(q.req.func)) begin
         mul_a = {q.opd[1][15], q.opd[1], q.opd[0]};
         mul_b = {q.opd[3][15], q.opd[3], q.opd[2]};
      end else begin
         mul_a = {{17{q.opd[0][15]}}, q.opd[0]};
         mul_b = {{17{q.opd[2][15]}}, q.opd[2]};
      end
   end

   spm_mul u_mul (
      .clk  (CLK),
      .nrst (NRST),
      .a    (mul_a),
      .b    (mul_b),
      .p    (prod)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic       dbl;
      logic       bcd;
      logic [1:0] slot;
      logic       need;
      logic       cst;
      logic [2:0] nres;
      logic [15:0] base;
      logic [63:0] adj;
      dbl  = spm_pkg::is_double(q.req.func);
      bcd  = spm_pkg::is_bcd_op(q.req.func);
      slot = q.idx[1:0];
      need = dbl || !slot[0];
      cst  = slot[1] ? q.req.mplier_const : q.req.mcand_const;
      nres = dbl ? spm_pkg::RES_WORDS_D : spm_pkg::RES_WORDS_S;
      base = slot[1] ? q.req.mplier_addr : q.req.mcand_addr;
      adj  = spm_pkg::dab_adjust(q.res);
      n         = q;
      n.rd      = 1'b0;
      n.we      = 1'b0;
      n.done    = 1'b0;
      n.rd_pend = 1'b0;
      if (q.rd_pend) begin
         n.opd[q.rd_slot] = STOR_RDATA;
      end
      unique case (q.st)
         spm_pkg::S_IDLE: begin
            if (START && spm_pkg::is_known(REQ.func)) begin
               n.req    = REQ;
               n.busy   = 1'b1;
               n.idx    = 3'h0;
               // constants preload every slot, the single form's high slots get zero; stored words overwrite later
               n.opd[0] = REQ.mcand_imm[15:0];
               n.opd[1] = spm_pkg::is_double(REQ.func) ? REQ.mcand_imm[31:16] : 16'h0000;
               n.opd[2] = REQ.mplier_imm[15:0];
               n.opd[3] = spm_pkg::is_double(REQ.func) ? REQ.mplier_imm[31:16] : 16'h0000;
               n.st     = spm_pkg::S_FETCH;
            end
         end
         spm_pkg::S_FETCH: begin
            if (q.idx < spm_pkg::SLOT_COUNT) begin
               if (need && !cst) begin
                  n.rd      = 1'b1;
                  n.raddr   = base + {15'h0000, slot[0]};
                  n.rd_pend = 1'b1;
                  n.rd_slot = slot;
               end
               n.idx = q.idx + 3'h1;
            end else if (!q.rd_pend) begin
               n.st = spm_pkg::S_MUL;
            end
         end
         spm_pkg::S_MUL: begin
            // word 1 and 3 are zero for the single form, so one check fits both
            n.bad = bcd && !(spm_pkg::is_bcd_word(q.opd[0]) &&
                             spm_pkg::is_bcd_word(q.opd[1]) &&
                             spm_pkg::is_bcd_word(q.opd[2]) &&
                             spm_pkg::is_bcd_word(q.opd[3]));
            n.st  = spm_pkg::S_PROD;
         end
         spm_pkg::S_PROD: begin
            n.idx = 3'h0;
            if (q.bad) begin
               n.st = spm_pkg::S_FIN;
            end else if (bcd) begin
               n.bin = prod;
               n.res = 64'h0000_0000_0000_0000;
               n.cnt = 7'h00;
               n.st  = spm_pkg::S_DAB;
            end else begin
               n.res = prod;
               n.st  = spm_pkg::S_WRITE;
            end
         end
         spm_pkg::S_DAB: begin
            // shift-add-3 conversion, one bit a cycle to keep the adders small
            // adjusted digits and binary shift left together as one register pair
            n.res = {adj[62:0], q.bin[63]};
            n.bin = {q.bin[62:0], 1'b0};
            n.cnt = q.cnt + 7'h01;
            if (q.cnt == spm_pkg::DAB_STEPS - 7'h01) begin
               n.st = spm_pkg::S_WRITE;
            end
         end
         spm_pkg::S_WRITE: begin
            n.we    = 1'b1;
            n.waddr = q.req.res_addr + {13'h0000, q.idx};
            n.wdata = q.res[16*q.idx[1:0] +: 16];
            n.idx   = q.idx + 3'h1;
            if (q.idx == nres - 3'h1) begin
               n.st = spm_pkg::S_FIN;
            end
         end
         spm_pkg::S_FIN: begin
            n.err = q.bad;
            if (!q.bad) begin
               n.zero = (q.res == 64'h0000_0000_0000_0000);
            end
            if (!bcd) begin
               n.neg = dbl ? q.res[63] : q.res[31];
            end
            n.done = 1'b1;
            n.busy = 1'b0;
            n.st   = spm_pkg::S_IDLE;
         end
         default: begin
            n.st = spm_pkg::S_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         q          <= '0;
         q.st       <= spm_pkg::S_IDLE;
         q.req.func <= spm_pkg::FUNC_RST;
         q.zero     <= spm_pkg::FLAG_RST;
         q.neg      <= spm_pkg::FLAG_RST;
         q.err      <= spm_pkg::FLAG_RST;
      end else begin
         q <= n;
      end
   end

   assign STOR_RD    = q.rd;
   assign STOR_RADDR = q.raddr;
   assign STOR_WE    = q.we;
   assign STOR_WADDR = q.waddr;
   assign STOR_WDATA = q.wdata;
   assign BUSY       = q.busy;
   assign DONE       = q.done;
   assign ZERO_FLAG  = q.zero;
   assign NEG_FLAG   = q.neg;
   assign ERROR_FLAG = q.err;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   logic signed [31:0] chk_s;
   logic signed [63:0] chk_d;
   assign chk_s = $signed(q.opd[0]) * $signed(q.opd[2]);
   assign chk_d = $signed({q.opd[1], q.opd[0]}) * $signed({q.opd[3], q.opd[2]});

   // word position of the current write, used to pick the expected slice
   logic [1:0] wr_pos;
   assign wr_pos = 2'(STOR_WADDR - q.req.res_addr);

   a_single_product: assert property (
      (DONE && q.req.func == spm_pkg::FN_MUL_S) |-> q.res[31:0] == chk_s)
      else $error("single signed product wrong");
   a_double_product: assert property (
      (DONE && q.req.func == spm_pkg::FN_MUL_SL) |-> q.res == chk_d)
      else $error("double signed product wrong");
   a_zero_flag: assert property (
      (DONE && !ERROR_FLAG) |-> ZERO_FLAG == (q.res == 64'h0000_0000_0000_0000))
      else $error("zero flag does not match product");
   a_neg_flag: assert property (
      (DONE && !spm_pkg::is_bcd_op(q.req.func)) |->
         NEG_FLAG == (spm_pkg::is_double(q.req.func) ? q.res[63] : q.res[31]))
      else $error("negative flag not product top bit");
   a_bcd_neg_hold: assert property (
      (DONE && spm_pkg::is_bcd_op(q.req.func)) |-> NEG_FLAG == $past(NEG_FLAG))
      else $error("negative flag moved on BCD multiply");
   a_signed_err_clr: assert property (
      (DONE && !spm_pkg::is_bcd_op(q.req.func)) |-> !ERROR_FLAG)
      else $error("error flag set after signed multiply");
   a_bcd_single_err: assert property (
      (DONE && q.req.func == spm_pkg::FN_MUL_B) |-> ERROR_FLAG ==
         !(spm_pkg::is_bcd_word(q.opd[0]) && spm_pkg::is_bcd_word(q.opd[2])))
      else $error("single BCD error flag wrong");
   a_bcd_double_err: assert property (
      (DONE && q.req.func == spm_pkg::FN_MUL_BL) |-> ERROR_FLAG ==
         !(spm_pkg::is_bcd_word(q.opd[0]) && spm_pkg::is_bcd_word(q.opd[1]) &&
           spm_pkg::is_bcd_word(q.opd[2]) && spm_pkg::is_bcd_word(q.opd[3])))
      else $error("double BCD error flag wrong");
   a_low_word_first: assert property (
      $rose(STOR_WE) |-> STOR_WADDR == q.req.res_addr && STOR_WDATA == q.res[15:0])
      else $error("first result word not the low word");
   a_write_to_done: assert property (
      ($fell(STOR_WE) && !spm_pkg::is_double(q.req.func)) |->
         DONE && $past(STOR_WADDR) == q.req.res_addr + 16'h0001)
      else $error("single result not two words");
   // a bad digit skips conversion, so latency is anchored after the product
   a_bcd_latency: assert property (
      (q.st == spm_pkg::S_PROD && spm_pkg::is_bcd_op(q.req.func) && !q.bad) |->
         ##[68:70] DONE)
      else $error("BCD multiply latency out of range");
   a_bad_skip: assert property (
      (q.st == spm_pkg::S_PROD && q.bad) |-> ##2 (DONE && ERROR_FLAG))
      else $error("bad BCD operand did not finish at once");
   a_bad_no_write: assert property (
      (BUSY && q.bad) |-> !STOR_WE)
      else $error("result written despite bad BCD operand");
   a_double_words: assert property (
      ($fell(STOR_WE) && spm_pkg::is_double(q.req.func)) |->
         DONE && $past(STOR_WADDR) == q.req.res_addr + 16'h0003)
      else $error("double result not four words");
   a_write_data: assert property (
      STOR_WE |-> STOR_WDATA == q.res[16*wr_pos +: 16])
      else $error("result word written to wrong place");

   ////////////////////////////////////////////////////////////////////////////
   // operand fetch: only stored operands touch storage, low word first
   a_read_stored: assert property (
      STOR_RD |-> !(q.rd_slot[1] ? q.req.mplier_const : q.req.mcand_const))
      else $error("storage read for a constant operand");
   a_read_addr: assert property (
      STOR_RD |-> STOR_RADDR ==
         (q.rd_slot[1] ? q.req.mplier_addr : q.req.mcand_addr) + {15'h0000, q.rd_slot[0]})
      else $error("operand read from wrong address");
   a_single_low_only: assert property (
      (STOR_RD && !spm_pkg::is_double(q.req.func)) |-> !q.rd_slot[0])
      else $error("single form read a high operand word");
   a_single_high_zero: assert property (
      (q.st == spm_pkg::S_MUL && !spm_pkg::is_double(q.req.func)) |->
         q.opd[1] == 16'h0000 && q.opd[3] == 16'h0000)
      else $error("single form high operand words not clear");

   ////////////////////////////////////////////////////////////////////////////
   // handshake: a strobe while busy must not disturb the latched request
   a_refuse_busy: assert property (
      (BUSY && START) |=> q.req == $past(q.req))
      else $error("request changed while busy");
   a_idle_quiet: assert property (
      !BUSY |-> !STOR_WE && !STOR_RD)
      else $error("storage strobe while idle");
   a_busy_done: assert property (
      $rose(DONE) |-> !BUSY && $past(BUSY))
      else $error("done without a busy operation");
   a_done_pulse: assert property (
      DONE |=> !DONE)
      else $error("done longer than one cycle");
   // flags move only with done, so readers may sample them at any time
   a_flags_hold: assert property (
      ($changed(ZERO_FLAG) || $changed(NEG_FLAG) || $changed(ERROR_FLAG)) |-> DONE)
      else $error("flag changed outside done");

   c_single_s: cover property (DONE && q.req.func == spm_pkg::FN_MUL_S);
   c_double_s: cover property (DONE && q.req.func == spm_pkg::FN_MUL_SL && NEG_FLAG);
   c_single_b: cover property (DONE && q.req.func == spm_pkg::FN_MUL_B && !ERROR_FLAG);
   c_double_b: cover property (DONE && q.req.func == spm_pkg::FN_MUL_BL && ERROR_FLAG);
   c_refused: cover property (BUSY && START);

endmodule : spm_unit
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic              CLK;
   logic              NRST;
   logic              START;
   spm_pkg::spm_req_s REQ;
   logic [15:0]       STOR_RDATA;
   logic              STOR_RD;
   logic [15:0]       STOR_RADDR;
   logic              STOR_WE;
   logic [15:0]       STOR_WADDR;
   logic [15:0]       STOR_WDATA;
   logic              BUSY;
   logic              DONE;
   logic              ZERO_FLAG;
   logic              NEG_FLAG;
   logic              ERROR_FLAG;
   logic [15:0]       mem [0:255];
   int                num_errors;
   int                n_checks;
   int                n_wr;
   int                op_wr;
   logic              again;

   spm_unit dut_u (.CLK(CLK), .NRST(NRST), .START(START), .REQ(REQ),
      .STOR_RDATA(STOR_RDATA), .STOR_RD(STOR_RD), .STOR_RADDR(STOR_RADDR),
      .STOR_WE(STOR_WE), .STOR_WADDR(STOR_WADDR), .STOR_WDATA(STOR_WDATA),
      .BUSY(BUSY), .DONE(DONE), .ZERO_FLAG(ZERO_FLAG), .NEG_FLAG(NEG_FLAG),
      .ERROR_FLAG(ERROR_FLAG));

   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end

   // read data appears at the falling edge inside the strobe cycle; otherwise
   // it toggles, so a capture one cycle off cannot pass
   always @(negedge CLK) begin
      STOR_RDATA <= STOR_RD ? mem[STOR_RADDR[7:0]] : ~STOR_RDATA;
      if (STOR_WE) begin
         mem[STOR_WADDR[7:0]] <= STOR_WDATA;
         n_wr <= n_wr + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask : chk

   task automatic wait_done;
      int i;
      for (i = 0; i < 200; i++) begin
         @(posedge CLK);
         #1;
         if (DONE === 1'b1) break;
      end
      if (i == 200) begin
         chk("done", 1, 0);
         stop_test();
      end
   endtask : wait_done

   // operands land in storage inverted when a constant is used, so a wrong
   // source selection cannot pass unnoticed
   task automatic op(input logic [9:0] f, input logic [31:0] a, input logic [31:0] b,
                     input logic ca, input logic cb);
      int n0;
      @(negedge CLK);
      {mem[8'h11], mem[8'h10]} = ca ? ~a : a;
      {mem[8'h21], mem[8'h20]} = cb ? ~b : b;
      for (int k = 0; k < 4; k++) mem[8'h30 + k] = 16'hA5A0 + 16'(k);
      n0 = n_wr;
      REQ = '{f, 16'h0010, 16'h0020, 16'h0030, ca, cb, a, b};
      START = 1'b1;
      @(negedge CLK);
      START = 1'b0;
      if (again) begin
         // second strobe with another code while busy must be dropped
         @(negedge CLK);
         REQ.func = spm_pkg::FN_MUL_BL;
         START = 1'b1;
         @(negedge CLK);
         START = 1'b0;
      end
      wait_done();
      op_wr = n_wr - n0;
   endtask : op

   task automatic res(input logic [63:0] e, input logic z, input logic n, input logic er);
      chk("product", e, {mem[8'h33], mem[8'h32], mem[8'h31], mem[8'h30]});
      chk("zero_flag", 64'(z), 64'(ZERO_FLAG));
      chk("neg_flag", 64'(n), 64'(NEG_FLAG));
      chk("error_flag", 64'(er), 64'(ERROR_FLAG));
   endtask : res

   ////////////////////////////////////////////////////////////////////////////
   task automatic s_bcd_single_bad;
      op(spm_pkg::FN_MUL_B, 32'h0000_12A4, 32'h0000_0003, 1'b0, 1'b0);
      res(64'hA5A3_A5A2_A5A1_A5A0, 1'b0, 1'b0, 1'b1);
      chk("writes", 0, op_wr);
   endtask : s_bcd_single_bad

   task automatic s_signed_single;
      op(spm_pkg::FN_MUL_S, 32'h0000_FFFD, 32'h0000_0007, 1'b0, 1'b0);
      res(64'hA5A3_A5A2_FFFF_FFEB, 1'b0, 1'b1, 1'b0);
      chk("writes", 2, op_wr);
   endtask : s_signed_single

   task automatic s_bcd_single_const;
      op(spm_pkg::FN_MUL_B, 32'h0000_1234, 32'h0000_5678, 1'b0, 1'b1);
      res(64'hA5A3_A5A2_0700_6652, 1'b0, 1'b1, 1'b0);
   endtask : s_bcd_single_const

   task automatic s_signed_double;
      op(spm_pkg::FN_MUL_SL, 32'h8000_0001, 32'h0000_0003, 1'b0, 1'b0);
      res(64'hFFFF_FFFE_8000_0003, 1'b0, 1'b1, 1'b0);
      chk("writes", 4, op_wr);
   endtask : s_signed_double

   task automatic s_signed_double_const;
      op(spm_pkg::FN_MUL_SL, 32'h0001_0000, 32'hFFFF_FFFF, 1'b1, 1'b0);
      res(64'hFFFF_FFFF_FFFF_0000, 1'b0, 1'b1, 1'b0);
   endtask : s_signed_double_const

   task automatic s_zero;
      op(spm_pkg::FN_MUL_S, 32'h0000_0000, 32'h0000_1234, 1'b1, 1'b0);
      res(64'hA5A3_A5A2_0000_0000, 1'b1, 1'b0, 1'b0);
   endtask : s_zero

   task automatic s_bcd_double;
      op(spm_pkg::FN_MUL_BL, 32'h1234_5678, 32'h8765_4321, 1'b0, 1'b0);
      res(64'h1082_1520_2237_4638, 1'b0, 1'b0, 1'b0);
      chk("writes", 4, op_wr);
   endtask : s_bcd_double

   task automatic s_bcd_double_bad;
      op(spm_pkg::FN_MUL_BL, 32'h1234_5678, 32'hB000_0001, 1'b0, 1'b0);
      res(64'hA5A3_A5A2_A5A1_A5A0, 1'b0, 1'b0, 1'b1);
   endtask : s_bcd_double_bad

   // unknown code and a second strobe during busy are both dropped silently
   task automatic s_refuse;
      int n0;
      @(negedge CLK);
      n0 = n_wr;
      REQ.func = 10'h1A6;
      START = 1'b1;
      @(negedge CLK);
      START = 1'b0;
      repeat (3) @(negedge CLK);
      chk("busy_unknown", 0, 64'(BUSY));
      again = 1'b1;
      op(spm_pkg::FN_MUL_S, 32'h0000_0002, 32'h0000_0003, 1'b1, 1'b1);
      again = 1'b0;
      res(64'hA5A3_A5A2_0000_0006, 1'b0, 1'b0, 1'b0);
      chk("writes_total", 2, n_wr - n0);
   endtask : s_refuse

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      NRST = 1'b0;
      START = 1'b0;
      REQ = '0;
      num_errors = 0;
      n_checks = 0;
      n_wr = 0;
      again = 1'b0;
      for (int k = 0; k < 256; k++) mem[k] = 16'h0000;
      repeat (10) @(negedge CLK);
      NRST = 1'b1;
      chk("reset_outputs", 0, {BUSY, DONE, ZERO_FLAG, NEG_FLAG, ERROR_FLAG, STOR_WE, STOR_RD});
      s_bcd_single_bad();
      s_signed_single();
      s_bcd_single_const();
      s_signed_double();
      s_signed_double_const();
      s_zero();
      s_bcd_double();
      s_bcd_double_bad();
      s_refuse();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
